// >>> reload_timer_pkg.sv
`default_nettype none
package reload_timer_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] COUNT_OFS  = 8'h04;
  localparam logic [7:0] RELOAD_OFS = 8'h08;
  localparam logic [7:0] CLKCFG_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] MASK_OFS   = 8'h14;

  // ----------------------------------------------------------------
  // timer_ctrl_reg field positions
  // ----------------------------------------------------------------
  localparam int CAP_SEL_BIT  = 0;
  localparam int CNT_SRC_BIT  = 1;
  localparam int RUN_BIT      = 2;
  localparam int TRIG_EN_BIT  = 3;
  localparam int TX_SEL_BIT   = 4;
  localparam int RX_SEL_BIT   = 5;
  localparam int TRIG_FLG_BIT = 6;
  localparam int OVF_FLG_BIT  = 7;

  // status and mask layout
  localparam int ST_OVF_BIT  = 0;
  localparam int ST_TRIG_BIT = 1;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [15:0] COUNT_TOP  = 16'hFFFF;
  localparam logic        CLK6_RST   = 1'b0;

  // divider limits, one less than the oscillator periods per machine cycle and per state time
  localparam logic [3:0] MC_DIV6_LIM     = 4'h5;
  localparam logic [3:0] MC_DIV12_LIM    = 4'hB;
  localparam logic [3:0] STATE_DIV6_LIM  = 4'h0;
  localparam logic [3:0] STATE_DIV12_LIM = 4'h1;

  // last baud count before a tick: one baud tick per sixteen overflows
  localparam logic [3:0] BAUD_DIV_LAST = 4'hF;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_RELOAD,
    MODE_CAPTURE,
    MODE_BAUD
  } timer_mode_e;

endpackage
`default_nettype wire

// >>> rate_divider.sv
`default_nettype none
module rate_divider
  import reload_timer_pkg::*;
#(
  parameter int W = 4
)
(
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  // control
  input  wire logic         enable,
  input  wire logic [W-1:0] limit,
  // pulse
  output logic              tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } div_s;

  div_s div_reg;
  div_s div_next;

  // ----------------------------------------------------------------
  // one pulse every limit+1 cycles while enabled
  // ----------------------------------------------------------------
  always_comb
  begin
    div_next      = div_reg;
    div_next.tick = 1'b0;
    if (!enable)
    begin
      div_next.cnt = '0;
    end
    else if (div_reg.cnt >= limit)
    begin
      div_next.cnt  = '0;
      div_next.tick = 1'b1;
    end
    else
    begin
      div_next.cnt = div_reg.cnt + W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_reg <= '0;
    end
    else
    begin
      div_reg <= div_next;
    end
  end

  assign tick = div_reg.tick;

endmodule
`default_nettype wire

// >>> reload_timer.sv
`default_nettype none
module reload_timer
  import reload_timer_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // pins
  input  wire logic        ext_clock_pin,
  input  wire logic        trigger_pin,
  // serial port baud ticks
  input  wire logic        t1_baud_tick,
  output logic             tx_baud_tick,
  output logic             rx_baud_tick,
  // interrupt
  output logic             irq
);

  typedef struct packed {
    logic        cap_sel;
    logic        cnt_src;
    logic        run;
    logic        trig_en;
    logic        tx_sel;
    logic        rx_sel;
    logic        clk6;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [15:0] count;
    logic [15:0] reload;
    logic [3:0]  baud_cnt;
    logic        tx_tick;
    logic        rx_tick;
    logic        ext_prev;
    logic        trig_prev;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
  } timer_s;

  timer_s      st_reg;
  timer_s      st_next;
  logic        mc_tick;
  logic        state_tick;
  timer_mode_e mode;
  logic        baud_mode;
  logic        ext_fall;
  logic        trig_fall;
  logic        step;
  logic        ovf;
  logic        baud_tick;
  logic [1:0]  flag_set;
  logic [1:0]  flag_clr;
  logic        rd_take;
  logic [7:0]  rd_addr;

  // ----------------------------------------------------------------
  // oscillator dividers
  // ----------------------------------------------------------------
  rate_divider #(
    .W (4)
  ) u_mc_div (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .enable  (st_reg.run),
    .limit   (st_reg.clk6 ? MC_DIV6_LIM : MC_DIV12_LIM),
    .tick    (mc_tick)
  );

  rate_divider #(
    .W (4)
  ) u_state_div (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .enable  (st_reg.run),
    .limit   (st_reg.clk6 ? STATE_DIV6_LIM : STATE_DIV12_LIM),
    .tick    (state_tick)
  );

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  always_comb
  begin
    baud_mode = st_reg.tx_sel | st_reg.rx_sel;
    if (!st_reg.run)
    begin
      mode = MODE_OFF;
    end
    else if (baud_mode)
    begin
      mode = MODE_BAUD;
    end
    else if (st_reg.cap_sel)
    begin
      mode = MODE_CAPTURE;
    end
    else
    begin
      mode = MODE_RELOAD;
    end
  end

  // ----------------------------------------------------------------
  // counter, flags and bus
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next           = st_reg;
    st_next.ext_prev  = ext_clock_pin;
    st_next.trig_prev = trigger_pin;
    ext_fall          = st_reg.ext_prev & ~ext_clock_pin;
    trig_fall         = st_reg.trig_prev & ~trigger_pin;
    baud_tick         = 1'b0;
    flag_set          = 2'b00;
    flag_clr          = 2'b00;

    // count source: pin edges, else state time in baud mode, else machine cycle
    if (st_reg.cnt_src)
    begin
      step = ext_fall;
    end
    else if (baud_mode)
    begin
      step = state_tick;
    end
    else
    begin
      step = mc_tick;
    end
    step = step & st_reg.run;
    ovf  = step & (st_reg.count == COUNT_TOP);

    if (step)
    begin
      st_next.count = st_reg.count + 16'h0001;
    end

    unique case (mode)
      MODE_OFF:
      begin
        st_next.baud_cnt = st_reg.baud_cnt;
      end
      MODE_RELOAD:
      begin
        if (ovf)
        begin
          st_next.count        = st_reg.reload;
          flag_set[ST_OVF_BIT] = 1'b1;
        end
        if (st_reg.trig_en && trig_fall)
        begin
          st_next.count = st_reg.reload;
        end
      end
      MODE_CAPTURE:
      begin
        if (ovf)
        begin
          flag_set[ST_OVF_BIT] = 1'b1;
        end
        if (st_reg.trig_en && trig_fall)
        begin
          st_next.reload = st_reg.count;
        end
      end
      MODE_BAUD:
      begin
        // rollover reloads but raises no flag, so the interrupt may stay enabled
        if (ovf)
        begin
          st_next.count    = st_reg.reload;
          st_next.baud_cnt = st_reg.baud_cnt + 4'h1;
          baud_tick        = (st_reg.baud_cnt == BAUD_DIV_LAST);
        end
      end
    endcase

    // trigger edge flags in every mode; in baud mode it never reloads
    if (st_reg.trig_en && trig_fall)
    begin
      flag_set[ST_TRIG_BIT] = 1'b1;
    end

    st_next.tx_tick = st_reg.tx_sel ? baud_tick : t1_baud_tick;
    st_next.rx_tick = st_reg.rx_sel ? baud_tick : t1_baud_tick;

    // data phase write; a software write to the counter beats the hardware step
    if (st_reg.wr_pend)
    begin
      unique case (st_reg.wr_addr)
        CTRL_OFS:
        begin
          st_next.cap_sel = hwdata[CAP_SEL_BIT];
          st_next.cnt_src = hwdata[CNT_SRC_BIT];
          st_next.run     = hwdata[RUN_BIT];
          st_next.trig_en = hwdata[TRIG_EN_BIT];
          st_next.tx_sel  = hwdata[TX_SEL_BIT];
          st_next.rx_sel  = hwdata[RX_SEL_BIT];
        end
        COUNT_OFS:
        begin
          st_next.count = hwdata[15:0];
        end
        RELOAD_OFS:
        begin
          st_next.reload = hwdata[15:0];
        end
        CLKCFG_OFS:
        begin
          st_next.clk6 = hwdata[0];
        end
        STATUS_OFS:
        begin
          flag_clr = hwdata[1:0];
        end
        MASK_OFS:
        begin
          st_next.mask = hwdata[1:0];
        end
        default:
        begin
          st_next.mask = st_reg.mask;
        end
      endcase
    end

    // a flag set in the same cycle as its clear survives
    st_next.status = (st_reg.status & ~flag_clr) | flag_set;

    // address phase
    rd_take         = hsel & htrans[1] & hready;
    rd_addr         = haddr[7:0];
    st_next.wr_pend = rd_take & hwrite;
    st_next.wr_addr = haddr[7:0];
    if (rd_take && !hwrite && (haddr[31:8] == 24'h000000))
    begin
      unique case (rd_addr)
        CTRL_OFS:
        begin
          st_next.rdata = {24'h000000, st_next.status[ST_OVF_BIT],
                           st_next.status[ST_TRIG_BIT], st_next.rx_sel,
                           st_next.tx_sel, st_next.trig_en, st_next.run,
                           st_next.cnt_src, st_next.cap_sel};
        end
        COUNT_OFS:
        begin
          st_next.rdata = {16'h0000, st_next.count};
        end
        RELOAD_OFS:
        begin
          st_next.rdata = {16'h0000, st_next.reload};
        end
        CLKCFG_OFS:
        begin
          st_next.rdata = {28'h0000000, st_reg.baud_cnt[3:2], mode == MODE_BAUD,
                           st_next.clk6};
        end
        STATUS_OFS:
        begin
          st_next.rdata = {30'h0, st_next.status};
        end
        MASK_OFS:
        begin
          st_next.rdata = {30'h0, st_next.mask};
        end
        default:
        begin
          st_next.rdata = 32'h00000000;
        end
      endcase
    end
    else if (rd_take)
    begin
      st_next.rdata = 32'h00000000;
    end
    // hsize is accepted as given: only whole-word transfers are expected
    if (hsize == 3'h7)
    begin
      st_next.wr_addr = haddr[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg          <= '0;
      st_reg.count    <= COUNT_RST;
      st_reg.reload   <= RELOAD_RST;
      st_reg.clk6     <= CLK6_RST;
      st_reg.ext_prev <= 1'b1;
      st_reg.trig_prev<= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // zero wait states: every access finishes in its first data cycle
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = st_reg.rdata;
  assign tx_baud_tick = st_reg.tx_tick;
  assign rx_baud_tick = st_reg.rx_tick;
  assign irq          = |(st_reg.status & st_reg.mask);

endmodule
`default_nettype wire

// >>> serial_baud_sink.sv
`default_nettype none
module serial_baud_sink
#(
  parameter int T1_DIV = 20
)
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // baud ticks
  input  wire logic tx_baud_tick,
  input  wire logic rx_baud_tick,
  output logic      t1_baud_tick,
  // last tick spacing
  output int        tx_per,
  output int        rx_per
);
  timeunit 1ns;
  timeprecision 1ps;
  int n;
  int tx_at;
  int rx_at;
  // spacing of the last two ticks only, so a stale first gap is forgotten
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      n <= 0;
      tx_at <= 0;
      rx_at <= 0;
      t1_baud_tick <= 1'b0;
      tx_per <= 0;
      rx_per <= 0;
    end
    else
    begin
      n <= n + 1;
      t1_baud_tick <= (n % T1_DIV) == 0;
      if (tx_baud_tick)
      begin
        tx_per <= n - tx_at;
        tx_at <= n;
      end
      if (rx_baud_tick)
      begin
        rx_per <= n - rx_at;
        rx_at <= n;
      end
    end
endmodule
`default_nettype wire

// >>> reload_timer_checker.sv
`default_nettype none
module reload_timer_checker
  import reload_timer_pkg::*;
(
  // clock and bus
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  // pins and ticks
  input wire logic        trigger_pin,
  input wire logic        t1_baud_tick,
  input wire logic        tx_baud_tick,
  input wire logic        rx_baud_tick,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       wr;
  logic [7:0] wa;
  logic [5:0] ctl;
  logic [1:0] msk;
  // shadow of control and mask, taken from the bus data phase
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      wr <= 1'b0;
      wa <= 8'h00;
      ctl <= 6'h00;
      msk <= 2'h0;
    end
    else
    begin
      wr <= hsel && htrans[1] && hready && hwrite;
      wa <= haddr[7:0];
      if (wr && wa == CTRL_OFS)
        ctl <= hwdata[5:0];
      if (wr && wa == MASK_OFS)
        msk <= hwdata[1:0];
    end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_tx_t1;
    !ctl[4] ##1 !ctl[4] |-> tx_baud_tick == $past(t1_baud_tick);
  endproperty
  a_tx_t1: assert property (p_tx_t1) else $error("tx tick not timer one");
  property p_rx_t1;
    !ctl[5] ##1 !ctl[5] |-> rx_baud_tick == $past(t1_baud_tick);
  endproperty
  a_rx_t1: assert property (p_rx_t1) else $error("rx tick not timer one");
  property p_tx_gap;
    ctl[4] && $past(ctl[4]) && tx_baud_tick |=> !tx_baud_tick;
  endproperty
  a_tx_gap: assert property (p_tx_gap) else $error("tx ticks too close");
  property p_rx_gap;
    ctl[5] && $past(ctl[5]) && rx_baud_tick |=> !rx_baud_tick;
  endproperty
  a_rx_gap: assert property (p_rx_gap) else $error("rx ticks too close");
  property p_same;
    ctl[5:4] == 2'b11 && $past(ctl[5:4]) == 2'b11 |-> tx_baud_tick == rx_baud_tick;
  endproperty
  a_same: assert property (p_same) else $error("tx and rx ticks differ");
  property p_off;
    (ctl == 6'h30) [*3] |-> !tx_baud_tick && !rx_baud_tick;
  endproperty
  a_off: assert property (p_off) else $error("tick while stopped");
  property p_trig;
    trigger_pin ##1 (!trigger_pin && ctl[3] && msk[1]) |-> ##[1:4] irq;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger edge missed");
  property p_sticky;
    irq && !wr && !$past(wr) |=> irq;
  endproperty
  a_sticky: assert property (p_sticky) else $error("irq dropped alone");
  property p_quiet;
    (ctl[5:4] != 2'b00 && !ctl[3] && !wr) [*4] |-> !$rose(irq);
  endproperty
  a_quiet: assert property (p_quiet) else $error("irq in baud mode");
endmodule
bind reload_timer reload_timer_checker u_reload_timer_checker (.sys_clk, .resetn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hwdata, .trigger_pin, .t1_baud_tick, .tx_baud_tick,
  .rx_baud_tick, .irq);
`default_nettype wire

// >>> reload_timer_test.sv
`default_nettype none
module reload_timer_test
  import reload_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, resetn = 0, hwrite = 0, ext_on = 0;
  logic ext_clock_pin = 1, trigger_pin = 1, hreadyout, hresp, t1, tx, rx, irq;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  int tx_per, rx_per, mismatches = 0, total_checks = 0, n;
  typedef struct {logic [7:0] c; logic k6; logic [15:0] v; int tx; int rx;} row_s;
  row_s rows[5] = '{'{8'h35, 1, 16'hFFFF, 16, 16}, '{8'h34, 0, 16'hFFFE, 64, 64},
    '{8'h24, 1, 16'hFFF0, 20, 256}, '{8'h14, 0, 16'hFFFF, 32, 20},
    '{8'h36, 1, 16'hFFFF, 32, 32}};
  logic [7:0] codes[11] = '{8'h00, 8'h08, 8'h01, 8'h09, 8'h34, 8'h24, 8'h14, 8'h02,
    8'h0A, 8'h03, 8'h0B};
  reload_timer u_reload_timer (.sys_clk, .resetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .ext_clock_pin, .trigger_pin, .t1_baud_tick(t1), .tx_baud_tick(tx),
    .rx_baud_tick(rx), .irq);
  serial_baud_sink u_serial_baud_sink (.sys_clk, .resetn, .tx_baud_tick(tx),
    .rx_baud_tick(rx), .t1_baud_tick(t1), .tx_per, .rx_per);
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    ext_clock_pin <= ext_on ? !ext_clock_pin : 1'b1;
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    check("register", r, exp);
  endtask
  task automatic trig;
    trigger_pin <= 1'b0;
    repeat (3) @(posedge sys_clk);
    trigger_pin <= 1'b1;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    give_verdict();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    // both interrupts unmasked, so a baud rollover that raised a flag would show
    wr(MASK_OFS, 32'h3);
    foreach (rows[i])
    begin
      wr(CTRL_OFS, 32'h00);
      ext_on <= rows[i].c[1];
      wr(CLKCFG_OFS, {31'h0, rows[i].k6});
      wr(RELOAD_OFS, {16'h0, rows[i].v});
      wr(COUNT_OFS, {16'h0, rows[i].v});
      wr(CTRL_OFS, {24'h0, rows[i].c});
      repeat (1100) @(posedge sys_clk);
      check("tx period", tx_per, rows[i].tx);
      check("rx period", rx_per, rows[i].rx);
      check("irq", irq, 0);
    end
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    ext_on <= 1'b0;
    for (int a = 0; a < 24; a += 4)
      rd(a[7:0], 32'h0);
    wr(8'h40, 32'h5);
    rd(8'h40, 32'h0);
    foreach (codes[i])
    begin
      wr(CTRL_OFS, {24'h0, codes[i]});
      rd(CTRL_OFS, {24'h0, codes[i]});
    end
    wr(CTRL_OFS, 32'h00);
    wr(CLKCFG_OFS, 32'h0);
    wr(RELOAD_OFS, 32'hFFF0);
    wr(COUNT_OFS, 32'hFFFE);
    wr(MASK_OFS, 32'h1);
    wr(CTRL_OFS, 32'h04);
    n = 0;
    while (irq !== 1'b1 && n < 60)
    begin
      @(posedge sys_clk);
      n++;
    end
    check("overflow delay", n >= 20 && n <= 30, 1);
    wr(CTRL_OFS, 32'h00);
    rd(COUNT_OFS, 32'hFFF0);
    rd(STATUS_OFS, 32'h1);
    wr(STATUS_OFS, 32'h1);
    rd(STATUS_OFS, 32'h0);
    check("irq", irq, 0);
    wr(COUNT_OFS, 32'h1234);
    wr(MASK_OFS, 32'h2);
    wr(CTRL_OFS, 32'h0F);
    trig();
    rd(RELOAD_OFS, 32'h1234);
    rd(STATUS_OFS, 32'h2);
    @(posedge sys_clk);
    ext_on <= 1'b1;
    repeat (6) @(posedge sys_clk);
    ext_on <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(COUNT_OFS, 32'h1237);
    wr(STATUS_OFS, 32'h3);
    wr(CTRL_OFS, 32'h00);
    wr(CLKCFG_OFS, 32'h1);
    wr(COUNT_OFS, 32'hFFF0);
    wr(CTRL_OFS, 32'h3C);
    trig();
    rd(RELOAD_OFS, 32'h1234);
    check("irq", irq, 1);
    // run past the first rollover, at which the count takes 1234 again
    repeat (20) @(posedge sys_clk);
    rd(STATUS_OFS, 32'h2);
    wr(CTRL_OFS, 32'h30);
    // a reload on the trigger edge would leave the count sixteen further on
    rd(COUNT_OFS, 32'h1240);
    repeat (40) @(posedge sys_clk);
    wr(STATUS_OFS, 32'h3);
    check("hresp", hresp, 0);
    check("hreadyout", hreadyout, 1);
    give_verdict();
  end
endmodule
`default_nettype wire
